/* wotc_pkg.sv */
package wotc_pkg;

   // Register indices; byte address is four times the index
   localparam logic [11:0] TCTL_IDX = 12'h108;
   localparam logic [11:0] OSCTL_IDX = 12'h109;
   localparam logic [11:0] TIOC_IDX = 12'h10a;
   localparam logic [11:0] TMODE_IDX = 12'h10b;
   localparam logic [11:0] PRE_IDX = 12'h10c;
   localparam logic [11:0] SEC_IDX = 12'h10d;
   localparam logic [11:0] PRI_IDX = 12'h10e;
   localparam int ADDR_W = 14;
   localparam int IDX_LSB = 2;

   // Timer control fields
   localparam int TCTL_START = 0;
   localparam int TCTL_STATUS = 1;
   localparam int TCTL_FSTOP = 2;

   // One-shot control fields
   localparam int OS_START = 0;
   localparam int OS_STOP = 1;
   localparam int OS_ACTIVE = 2;

   // Trigger and output control fields
   localparam int TIOC_LEVEL = 0;
   localparam int TIOC_OSW = 1;
   localparam int TIOC_PINEN = 2;
   localparam int TIOC_EDGE = 3;
   localparam logic [7:0] TIOC_WMASK = 8'h0f;
   localparam logic [7:0] TIOC_RST = 8'h00;

   // Mode register: count source select
   localparam int SRC_LSB = 0;
   localparam int SRC_W = 2;
   localparam logic [7:0] TMODE_WMASK = 8'h03;

   // Reset values of the counting registers
   localparam logic [7:0] PRE_RST = 8'hff;
   localparam logic [7:0] PRI_RST = 8'hff;
   localparam logic [7:0] SEC_RST = 8'hff;
   localparam logic [7:0] CNT_ZERO = 8'h00;

   // Count source choices
   typedef enum logic [1:0] {
      SRC_F1,
      SRC_F2,
      SRC_F8,
      SRC_COMPANION
   } wotc_src_t;
   localparam logic [2:0] DIV2_LAST = 3'h1;
   localparam logic [2:0] DIV8_LAST = 3'h7;

   // Counting phase of a one-shot
   typedef enum logic {
      PH_WAIT,
      PH_PULSE
   } wotc_phase_t;

endpackage : wotc_pkg

/* wotc_src_div.sv */
`timescale 1ns/1ps
`default_nettype none
// Count source: one-cycle enable pulses at the chosen rate
module wotc_src_div
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [wotc_pkg::SRC_W-1:0] src_sel,
   input wire logic companion_uf,
   output logic src_tick
);
   import wotc_pkg::*;

   // Free running prescale counter
   logic [2:0] div_q;
   logic [2:0] last;

   // Wrap point for the selected rate
   always_comb
   begin
      last = (src_sel == SRC_F8) ? DIV8_LAST : DIV2_LAST;
   end

   // Divider advance
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         div_q <= 3'h0;
      else if (div_q >= last)
         div_q <= 3'h0;
      else
         div_q <= div_q + 3'h1;
   end

   // Tick select; companion underflow is used as delivered
   always_comb
   begin
      unique case (wotc_src_t'(src_sel))
         SRC_F1: src_tick = 1'b1;
         SRC_F2, SRC_F8: src_tick = (div_q == last);
         SRC_COMPANION: src_tick = companion_uf;
      endcase
   end
endmodule : wotc_src_div
`default_nettype wire

/* wotc_trig_edge.sv */
`timescale 1ns/1ps
`default_nettype none
// External trigger edge detector
module wotc_trig_edge
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic trig_pin,
   input wire logic pin_en,
   input wire logic rise_sel,
   output logic trig_pulse
);
   import wotc_pkg::*;

   // Previous pin level
   logic prev_q;

   // Pin history
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prev_q <= 1'b0;
      else
         prev_q <= trig_pin;
   end

   // Chosen edge, gated by the pin enable
   always_comb
   begin
      if (!pin_en)
         trig_pulse = 1'b0;
      else if (rise_sel)
         trig_pulse = trig_pin && !prev_q;
      else
         trig_pulse = !trig_pin && prev_q;
   end
endmodule : wotc_trig_edge
`default_nettype wire

/* wotc_top.sv */
// Functional notes
// - Level select sets pulse and idle polarity
// - Pin edges trigger only when enabled
// - Edge select: zero falling, one rising
// - Upper control bits read zero
// - Timer stopped after reset
// - Count bytes read separately, may change
// - Stop reloads counter, then halts
// - Status rises one-two source cycles later
// - Status falls one-two source cycles later
// - Forced stop halts at once
// - Active flag follows after one-two cycles
// - Crossed start/stop leaves either value
// - Wait lasts (pre+1)(pri+1) source cycles
// - Pulse lasts (pre+1)(sec+1) source cycles
// - Primary underflow loads secondary, secondary ends
// - Request raised as pulse ends
`timescale 1ns/1ps
`default_nettype none
module wotc_top
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [wotc_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic external_trigger_pin,
   input wire logic companion_uf,
   output logic pulse_output_pin,
   output logic timer_irq
);
   import wotc_pkg::*;

   // Index hit test, shared by read and write paths
   function automatic logic idx_hit(input logic [ADDR_W-1:0] a, input logic [11:0] idx);
      idx_hit = (a[1:0] == 2'b00) && (a[ADDR_W-1:IDX_LSB] == idx);
   endfunction : idx_hit

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      mapped = idx_hit(a, TCTL_IDX) || idx_hit(a, OSCTL_IDX) || idx_hit(a, TIOC_IDX)
         || idx_hit(a, TMODE_IDX) || idx_hit(a, PRE_IDX) || idx_hit(a, SEC_IDX)
         || idx_hit(a, PRI_IDX);
   endfunction : mapped

   // Software state
   logic start_q;       // Count start bit
   logic [7:0] tioc_q;  // Trigger and output control
   logic [7:0] tmode_q; // Count source select
   logic [7:0] pre_rld_q, pri_rld_q, sec_rld_q;
   // Counting state
   logic sync_q;        // Start seen in count source domain
   logic status_q;      // Count status flag
   logic os_pend_q;     // One-shot request waiting
   logic os_stage_q;    // Second step of request sync
   logic os_req_q;      // 1 start, 0 stop
   logic os_active_q;   // One-shot active flag
   logic [7:0] pre_cnt_q, main_cnt_q;
   wotc_phase_t phase_q;
   logic [31:0] prdata_q;
   logic irq_q;
   logic pulse_q;
   // Strobes
   logic wr, src_tick, pin_trig, sw_trig, sw_stop, fstop, trig;
   logic pre_uf, main_uf, sec_uf, halt;

   assign wr = psel && penable && pwrite && mapped(paddr);
   assign sw_trig = wr && idx_hit(paddr, OSCTL_IDX) && pwdata[OS_START];
   assign sw_stop = wr && idx_hit(paddr, OSCTL_IDX) && pwdata[OS_STOP];
   assign fstop = wr && idx_hit(paddr, TCTL_IDX) && pwdata[TCTL_FSTOP];

   // Count source divider
   wotc_src_div u_div (
      .pclk(pclk),
      .presetn(presetn),
      .src_sel(tmode_q[SRC_LSB +: SRC_W]),
      .companion_uf(companion_uf),
      .src_tick(src_tick)
   );

   wotc_trig_edge u_trig (
      .pclk(pclk),
      .presetn(presetn),
      .trig_pin(external_trigger_pin),
      .pin_en(tioc_q[TIOC_PINEN]),
      .rise_sel(tioc_q[TIOC_EDGE]),
      .trig_pulse(pin_trig)
   );

   // Triggers while active are ignored, no retrigger
   assign trig = (sw_trig || pin_trig) && status_q && !os_active_q;

   // APB: zero wait, data latched in setup
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped(paddr);
   assign prdata = prdata_q;

   // Underflow chain while counting
   assign pre_uf = status_q && os_active_q && src_tick && (pre_cnt_q == CNT_ZERO);
   assign main_uf = pre_uf && (main_cnt_q == CNT_ZERO);
   assign sec_uf = main_uf && (phase_q == PH_PULSE);
   assign halt = (src_tick && os_stage_q && !os_req_q) || (src_tick && sync_q == 1'b0
      && status_q);

   // Read mux; upper bits zero, prescaler and primary bytes are live counts, secondary byte is its reload value
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_q <= 32'h0;
      else if (psel && !penable)
      begin
         prdata_q <= 32'h0;
         if (idx_hit(paddr, TCTL_IDX))
            prdata_q[TCTL_STATUS:TCTL_START] <= {status_q, start_q};
         else if (idx_hit(paddr, OSCTL_IDX))
            prdata_q[OS_ACTIVE] <= os_active_q;
         else if (idx_hit(paddr, TIOC_IDX))
            prdata_q[7:0] <= tioc_q;
         else if (idx_hit(paddr, TMODE_IDX))
            prdata_q[7:0] <= tmode_q;
         else if (idx_hit(paddr, PRE_IDX))
            prdata_q[7:0] <= pre_cnt_q;
         else if (idx_hit(paddr, SEC_IDX))
            prdata_q[7:0] <= sec_rld_q;
         else if (idx_hit(paddr, PRI_IDX))
            prdata_q[7:0] <= main_cnt_q;
      end
   end

   // Control register writes; start cleared at reset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         start_q <= 1'b0;
         tioc_q <= TIOC_RST;
         tmode_q <= 8'h00;
      end
      else if (fstop)
         start_q <= 1'b0;
      else if (wr)
      begin
         if (idx_hit(paddr, TCTL_IDX))
            start_q <= pwdata[TCTL_START];
         if (idx_hit(paddr, TIOC_IDX))
            tioc_q <= pwdata[7:0] & TIOC_WMASK;
         if (idx_hit(paddr, TMODE_IDX))
            tmode_q <= pwdata[7:0] & TMODE_WMASK;
      end
   end

   // Reload registers always take writes
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pre_rld_q <= PRE_RST;
         pri_rld_q <= PRI_RST;
         sec_rld_q <= SEC_RST;
      end
      else if (wr)
      begin
         if (idx_hit(paddr, PRE_IDX))
            pre_rld_q <= pwdata[7:0];
         if (idx_hit(paddr, PRI_IDX))
            pri_rld_q <= pwdata[7:0];
         if (idx_hit(paddr, SEC_IDX))
            sec_rld_q <= pwdata[7:0];
      end
   end

   // status rises after one or two source ticks
   // status falls after one or two source ticks
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync_q <= 1'b0;
         status_q <= 1'b0;
      end
      // no wait for the count source
      else if (fstop)
      begin
         sync_q <= 1'b0;
         status_q <= 1'b0;
      end
      else if (src_tick)
      begin
         sync_q <= start_q;
         status_q <= sync_q;
      end
   end

   // active flag changes on the second tick
   // latest request wins when requests cross
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         os_pend_q <= 1'b0;
         os_stage_q <= 1'b0;
         os_req_q <= 1'b0;
         os_active_q <= 1'b0;
      end
      else if (fstop || (src_tick && !sync_q))
      begin
         os_pend_q <= 1'b0;
         os_stage_q <= 1'b0;
         os_active_q <= 1'b0;
      end
      else
      begin
         // New request restarts the sync, wins over a tick
         if (trig || sw_stop)
         begin
            os_pend_q <= 1'b1;
            os_stage_q <= 1'b0;
            os_req_q <= trig;
         end
         else if (src_tick && os_stage_q)
         begin
            os_pend_q <= 1'b0;
            os_stage_q <= 1'b0;
            os_active_q <= os_req_q;
         end
         else if (src_tick && os_pend_q)
            os_stage_q <= 1'b1;
         if (sec_uf)
            os_active_q <= 1'b0;
      end
   end

   // Prescaler and main counter
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pre_cnt_q <= PRE_RST;
         main_cnt_q <= PRI_RST;
         phase_q <= PH_WAIT;
      end
      // reload and stop, live count lost
      else if (fstop || halt)
      begin
         pre_cnt_q <= pre_rld_q;
         main_cnt_q <= pri_rld_q;
         phase_q <= PH_WAIT;
      end
      else if (!status_q && wr && idx_hit(paddr, PRE_IDX))
         pre_cnt_q <= pwdata[7:0];
      else if (!status_q && wr && idx_hit(paddr, PRI_IDX))
         main_cnt_q <= pwdata[7:0];
      else if (status_q && os_active_q && src_tick)
      begin
         if (pre_cnt_q == CNT_ZERO)
            pre_cnt_q <= pre_rld_q;
         else
            pre_cnt_q <= pre_cnt_q - 8'h01;
         if (pre_uf)
         begin
            if (!main_uf)
               main_cnt_q <= main_cnt_q - 8'h01;
            else
            begin
               // primary loads secondary, secondary loads primary
               unique case (phase_q)
                  PH_WAIT:
                  begin
                     main_cnt_q <= sec_rld_q;
                     phase_q <= PH_PULSE;
                  end
                  PH_PULSE:
                  begin
                     main_cnt_q <= pri_rld_q;
                     phase_q <= PH_WAIT;
                  end
               endcase
            end
         end
      end
   end

   // pulse level inverted from idle level
   // request and pulse end on the same edge
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pulse_q <= 1'b0;
         irq_q <= 1'b0;
      end
      else
      begin
         // Rise and fall on the phase edges, so the width is exact in ticks
         if (fstop || halt || sec_uf)
            pulse_q <= 1'b0;
         else if (main_uf && phase_q == PH_WAIT)
            pulse_q <= 1'b1;
         irq_q <= sec_uf;
      end
   end

   assign pulse_output_pin = pulse_q ^ tioc_q[TIOC_LEVEL];
   assign timer_irq = irq_q;

   // pin leaves idle level only in pulse
   a_pulse_level: assert property (@(posedge pclk) disable iff (!presetn)
      (pulse_output_pin != tioc_q[TIOC_LEVEL]) |-> phase_q == PH_PULSE && os_active_q)
      else $error("pulse output active outside pulse phase");
   a_pin_gate: assert property (@(posedge pclk) disable iff (!presetn)
      pin_trig |-> tioc_q[TIOC_PINEN])
      else $error("pin trigger while disabled");
   a_trig_edge: assert property (@(posedge pclk) disable iff (!presetn)
      pin_trig |-> (external_trigger_pin == tioc_q[TIOC_EDGE])
      && (external_trigger_pin != $past(external_trigger_pin)))
      else $error("trigger on wrong edge");
   a_tioc_resv: assert property (@(posedge pclk) disable iff (!presetn)
      tioc_q[7:4] == 4'h0)
      else $error("reserved trigger control bits set");
   // status rises only after start seen twice
   a_status_rise: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(status_q) |-> $past(sync_q) && $past(src_tick))
      else $error("status rose without sync");
   a_force_stop: assert property (@(posedge pclk) disable iff (!presetn)
      fstop |=> !status_q && !os_active_q && !start_q)
      else $error("forced stop did not halt");
   // active flag rises only from staged request
   a_os_rise: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(os_active_q) |-> $past(os_stage_q) && $past(src_tick))
      else $error("active flag rose too early");
   a_sec_end: assert property (@(posedge pclk) disable iff (!presetn)
      sec_uf |=> !os_active_q && main_cnt_q == $past(pri_rld_q))
      else $error("secondary underflow did not end");
   a_irq_edge: assert property (@(posedge pclk) disable iff (!presetn)
      timer_irq |-> !pulse_q && $past(pulse_q))
      else $error("request not at pulse end");

   c_oneshot: cover property (@(posedge pclk) disable iff (!presetn) $rose(os_active_q));
   c_pulse_end: cover property (@(posedge pclk) disable iff (!presetn) timer_irq);
   c_force: cover property (@(posedge pclk) disable iff (!presetn) fstop && os_active_q);
endmodule : wotc_top
`default_nettype wire

/* wotc_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Far side: trigger source, companion ticks and pulse load
module wotc_far_model
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pin_req,
   input wire logic idle_level,
   input wire logic pulse_output_pin,
   input wire logic timer_irq,
   output logic external_trigger_pin,
   output logic companion_uf,
   output int pulse_width,
   output int pulse_count,
   output logic irq_at_end
);
   logic [1:0] div_q; // Companion prescale
   int run_q; // Cycles away from idle so far

   // companion in timer mode
   // Free-running companion, underflow every fourth clock
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div_q <= 2'h0;
         companion_uf <= 1'b0;
      end
      else
      begin
         div_q <= div_q + 2'h1;
         companion_uf <= (div_q == 2'h3);
      end
   end

   // Trigger line moves only just after an edge
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         external_trigger_pin <= 1'b0;
      else
         external_trigger_pin <= pin_req;
   end

   // Load: width of each excursion, irq sampled as it ends
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         run_q <= 0;
         pulse_width <= 0;
         pulse_count <= 0;
         irq_at_end <= 1'b0;
      end
      else if (pulse_output_pin !== idle_level)
         run_q <= run_q + 1;
      else if (run_q > 0)
      begin
         pulse_width <= run_q;
         pulse_count <= pulse_count + 1;
         irq_at_end <= timer_irq;
         run_q <= 0;
      end
   end
endmodule : wotc_far_model
`default_nettype wire

/* wait_oneshot_timer_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module wait_oneshot_timer_control_tb;
   import wotc_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = 14'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, pulse_output_pin, timer_irq;
   logic external_trigger_pin, companion_uf, irq_at_end;
   logic pin_req = 1'b0; // Requested trigger level
   logic lv = 1'b0; // Expected idle level
   int pulse_width, pulse_count;
   logic [31:0] rd; // Last read data
   logic err; // Last error response
   logic [31:0] seed = 32'hc24566fa;
   int fails = 0;
   int compares = 0;
   int dv[4] = '{1, 2, 8, 4}; // Clocks per tick for each source

   // 250 MHz clock
   always #2 pclk = ~pclk;

   wotc_top wotc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .external_trigger_pin(external_trigger_pin),
      .companion_uf(companion_uf), .pulse_output_pin(pulse_output_pin),
      .timer_irq(timer_irq));
   wotc_far_model wotc_far_model_i (.pclk(pclk), .presetn(presetn), .pin_req(pin_req),
      .idle_level(lv), .pulse_output_pin(pulse_output_pin), .timer_irq(timer_irq),
      .external_trigger_pin(external_trigger_pin), .companion_uf(companion_uf),
      .pulse_width(pulse_width), .pulse_count(pulse_count), .irq_at_end(irq_at_end));

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   // One APB transfer, held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [11:0] idx, input logic [7:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, wd};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk iff pready === 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Bounded poll of one bit; nothing else touched meanwhile
   task automatic poll(input logic [11:0] idx, input int b, input logic v);
      int n;
      n = 0;
      do
      begin
         apb(1'b0, idx, 8'h00);
         n++;
      end
      while (rd[b] !== v && n < 40);
      chk({31'h0, rd[b]}, {31'h0, v});
   endtask : poll

   // Stop, load reloads while stopped, then start counting
   task automatic arm(input logic [7:0] md, pre, pri, sec, tioc);
      apb(1'b1, TCTL_IDX, 8'h00);
      poll(TCTL_IDX, TCTL_STATUS, 1'b0);
      apb(1'b1, TMODE_IDX, md);
      apb(1'b1, PRE_IDX, pre);
      apb(1'b1, PRI_IDX, pri);
      apb(1'b1, SEC_IDX, sec);
      apb(1'b1, TIOC_IDX, tioc & 8'hfd);
      apb(1'b1, TCTL_IDX, 8'h01);
      poll(TCTL_IDX, TCTL_STATUS, 1'b1);
   endtask : arm

   // Trigger one shot and judge wait, width and end
   task automatic fire(input logic pin, e, input int pre, pri, sec, d);
      int base;
      int t;
      int w;
      w = (pre + 1) * (pri + 1) * d;
      base = pulse_count;
      t = 0;
      if (pin)
         pin_req <= e;
      else
         apb(1'b1, OSCTL_IDX, 8'h01);
      while (pulse_output_pin === lv && t < 4000)
      begin
         @(posedge pclk);
         t++;
      end
      chk({31'h0, t >= w && t <= w + 8 * d + 8}, 32'h1);
      while (pulse_count == base && t < 8000)
      begin
         @(posedge pclk);
         t++;
      end
      chk(pulse_width, (pre + 1) * (sec + 1) * d);
      chk({31'h0, irq_at_end}, 32'h1);
      chk({31'h0, pulse_output_pin}, {31'h0, lv});
      poll(OSCTL_IDX, OS_ACTIVE, 1'b0);
   endtask : fire

   task automatic tally_and_finish();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish

   // Main sequence
   initial
   begin
      int pre, pri, sec, base;
      logic e;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, TIOC_IDX, 8'h00);
      chk(rd, 32'h0);
      apb(1'b0, PRE_IDX, 8'h00);
      chk(rd, {24'h0, PRE_RST});
      apb(1'b0, TCTL_IDX, 8'h00);
      chk({31'h0, rd[TCTL_STATUS]}, 32'h0);
      // Unassigned bits written high on purpose
      apb(1'b1, TIOC_IDX, 8'hf0);
      apb(1'b0, TIOC_IDX, 8'h00);
      chk(rd, 32'h0);
      apb(1'b0, 12'h1ff, 8'h00);
      chk({31'h0, err}, 32'h1);
      $display("test reset done");
      // Every count source, both levels, both trigger kinds
      for (int i = 0; i < 4; i++)
      begin
         seed = lfsr_next(seed);
         pre = int'(seed[1:0]);
         pri = int'(seed[3:2]);
         sec = int'(seed[5:4]);
         e = i[0];
         pin_req <= e;
         arm(8'(i), 8'(pre), 8'(pri), 8'(sec), {4'h0, e, 2'b00, e});
         lv <= e;
         repeat (2) @(posedge pclk);
         if (i >= 2)
         begin
            // disabled pin and wrong edge ignored
            base = pulse_count;
            pin_req <= ~e;
            repeat (200) @(posedge pclk);
            pin_req <= e;
            repeat (200) @(posedge pclk);
            chk(pulse_count, base);
            apb(1'b1, TIOC_IDX, {4'h0, e, 3'b100} | {7'h0, e});
            pin_req <= ~e;
            repeat (200) @(posedge pclk);
            chk(pulse_count, base);
         end
         fire(i >= 2, e, pre, pri, sec, dv[i]);
         $display("test %0d done", i);
      end
      // stop reloads and cancels the pending pulse
      arm(8'h02, 8'h00, 8'h40, 8'h01, 8'h00);
      lv <= 1'b0;
      repeat (2) @(posedge pclk);
      base = pulse_count;
      apb(1'b1, OSCTL_IDX, 8'h01);
      repeat (40) @(posedge pclk);
      apb(1'b1, OSCTL_IDX, 8'h02);
      poll(OSCTL_IDX, OS_ACTIVE, 1'b0);
      apb(1'b0, PRI_IDX, 8'h00);
      chk(rd, 32'h40);
      repeat (600) @(posedge pclk);
      chk(pulse_count, base);
      // forced stop during a wait drops status and shot at once
      apb(1'b1, OSCTL_IDX, 8'h01);
      repeat (40) @(posedge pclk);
      apb(1'b1, TCTL_IDX, 8'h04);
      apb(1'b0, TCTL_IDX, 8'h00);
      chk({31'h0, rd[TCTL_STATUS]}, 32'h0);
      apb(1'b0, OSCTL_IDX, 8'h00);
      chk({31'h0, rd[OS_ACTIVE]}, 32'h0);
      $display("test stop done");
      tally_and_finish();
   end

   // Watchdog, well beyond the expected run length
   initial
   begin
      repeat (60000) @(posedge pclk);
      fails++;
      $display("mismatch at %0t: watchdog expired", $time);
      tally_and_finish();
   end
endmodule : wait_oneshot_timer_control_tb
`default_nettype wire
